/* logic/nvm_map.vh */
// address map, field positions, reset values and timing counts of the nvm block
`ifndef NVM_MAP_VH
`define NVM_MAP_VH
`define NVM_RAM_LO 12'h000
`define NVM_RAM_HI 12'h03F
`define NVM_DEE_LO 12'h040
`define NVM_DEE_HI 12'h07F
`define NVM_DEE_UPPER_LO 12'h060
`define NVM_STATUS_ADDR 12'h0CF
`define NVM_CODE_LO 12'hC00
`define NVM_CODE_HI 12'hFF5
`define NVM_VEC_LO 12'hFF6
`define NVM_VEC_HI 12'hFFD
`define NVM_VEC_T0 12'hFF6
`define NVM_VEC_T1 12'hFF8
`define NVM_VEC_WAKE 12'hFFA
`define NVM_VEC_SW 12'hFFC
`define NVM_CFG1_ADDR 12'hFFE
`define NVM_CFG2_ADDR 12'hFFF
`define NVM_BIT_RD_LOCK 0
`define NVM_BIT_WR_LOCK 1
`define NVM_BIT_UB_LOCK 2
`define NVM_BIT_LBD_EN 3
`define NVM_BIT_BOR_EN 4
`define NVM_BIT_WD_EN 5
`define NVM_BIT_CLOCK_MODE_BIT_ONE 6
`define NVM_BIT_CLOCK_MODE_BIT_ZERO 7
`define NVM_BIT_READY 0
`define NVM_CFG1_RESET 8'h00
`define NVM_CFG2_RESET 8'h80
`define NVM_WRITE_TIME_US 3000
`define NVM_CLK_MHZ 10
`define NVM_WRITE_CYCLES (`NVM_WRITE_TIME_US * `NVM_CLK_MHZ)
`define NVM_LOAD_CYCLES 4
`endif

/* logic/nvm_pin_sync.v */
// three-stage synchroniser for an asynchronous level input
`timescale 1ns/1ps
module nvm_pin_sync (
	ref_clk,
	arst_n,
	pin_in,
	level_out
);
input wire ref_clk;
input wire arst_n;
input wire pin_in;
output reg level_out;
reg s1_r;
reg s2_r;
reg s3_r;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		s1_r <= 1'b0;
		s2_r <= 1'b0;
		s3_r <= 1'b0;
		level_out <= 1'b0;
	end else begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
		// change counts only once stages two and three agree
		if (s2_r == s3_r)
			level_out <= s3_r;
	end
end
endmodule // nvm_pin_sync

/* logic/nvm_write_timer.v */
// busy timer for one data eeprom write cycle
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_write_timer #(
	parameter WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
	ref_clk,
	arst_n,
	start,
	busy
);
input wire ref_clk;
input wire arst_n;
input wire start;
output reg busy;
reg [15:0] cnt_r;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		cnt_r <= 16'h0000;
		busy <= 1'b0;
	end else if (start && !busy) begin
		cnt_r <= WRITE_CYCLES[15:0] - 16'h0001;
		busy <= 1'b1;
	end else if (busy) begin
		if (cnt_r == 16'h0000)
			busy <= 1'b0;
		else
			cnt_r <= cnt_r - 16'h0001;
	end
end
endmodule // nvm_write_timer

/* logic/nvm_ctrl.v */
// memory decode and nonvolatile access control for the core bus
// Behaviour
// RULE1: all registers except acc, pc are mapped
// RULE2: 0x00-0x3F ram, 0x40-0x7F data eeprom
// RULE3: code 0xC00-0xFF5, vectors 0xFF6-0xFFD
// RULE4: normal mode ignores code eeprom writes
// RULE5: code writes only in program mode, unlocked
// RULE6: status ready bit: 1 ready, 0 busy
// RULE7: hardware clears and sets ready flag
// RULE8: software polls ready before each write
// RULE9: two config bytes loaded at power-up
// RULE10: second byte is oscillator trim output
// RULE11: config bytes read/write in program mode
// RULE12: config one bit layout, locks to clock
// RULE13: read lock refuses reads in program mode
// RULE14: upper-block lock blocks upper eeprom writes
// RULE15: detector follows detect enable bit
// RULE16: brown-out reset allowed when enabled
// RULE17: watchdog enable bit activates watchdog
// RULE18: both locks set forbid program mode
// RULE19: locks clearable while write lock clear
// RULE20: clock mode bits passed through opaque
// RULE21: data eeprom store starts busy cycle
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_ctrl #(
	parameter WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
	ref_clk,
	arst_n,
	bus_addr,
	bus_wdata,
	bus_wr,
	bus_rd,
	bus_rdata,
	bus_ack,
	prog_mode_pin,
	supply_low,
	nvm_ready,
	prog_mode_active,
	low_battery_detector_on,
	brownout_reset_req,
	watchdog_enable_bit,
	clock_mode_sel,
	osc_trim,
	config_loaded,
	periph_sel,
	core_reg_sel
);
input wire ref_clk;
input wire arst_n;
input wire [11:0] bus_addr;
input wire [7:0] bus_wdata;
input wire bus_wr;
input wire bus_rd;
output reg [7:0] bus_rdata;
output reg bus_ack;
input wire prog_mode_pin;
input wire supply_low;
output reg nvm_ready;
output reg prog_mode_active;
output reg low_battery_detector_on;
output reg brownout_reset_req;
output reg watchdog_enable_bit;
output reg [1:0] clock_mode_sel;
output reg [7:0] osc_trim;
output reg config_loaded;
output reg periph_sel;
output reg core_reg_sel;

localparam ST_LOAD1 = 2'd0;
localparam ST_LOAD2 = 2'd1;
localparam ST_RUN = 2'd2;

localparam RG_NONE = 3'd0;
localparam RG_RAM = 3'd1;
localparam RG_DEE = 3'd2;
localparam RG_CODE = 3'd3;
localparam RG_VEC = 3'd4;
localparam RG_STAT = 3'd5;
localparam RG_CFG = 3'd6;
localparam RG_PERI = 3'd7;

// address decoder, shared by read and write paths
function [2:0] region;
	input [11:0] a;
	begin
		if (a <= `NVM_RAM_HI) // [RULE2]
			region = RG_RAM;
		else if (a >= `NVM_DEE_LO && a <= `NVM_DEE_HI) // [RULE2]
			region = RG_DEE;
		else if (a == `NVM_STATUS_ADDR) // [RULE1]
			region = RG_STAT;
		else if (a >= 12'h080 && a <= 12'h0CE) // [RULE1]
			region = RG_PERI;
		else if (a >= `NVM_CODE_LO && a <= `NVM_CODE_HI) // [RULE3]
			region = RG_CODE;
		else if (a >= `NVM_VEC_LO && a <= `NVM_VEC_HI) // [RULE3]
			region = RG_VEC;
		else if (a == `NVM_CFG1_ADDR || a == `NVM_CFG2_ADDR)
			region = RG_CFG;
		else
			region = RG_NONE;
	end
endfunction

reg [7:0] ram_mem [0:63];
reg [7:0] dee_mem [0:63];
// code array covers program storage and the vector slots
reg [7:0] code_mem [0:1023];
integer init_i;
// eeprom arrays start erased, ram is left uninitialised; the config slots hold their unprogrammed defaults
initial begin
	for (init_i = 0; init_i < 1024; init_i = init_i + 1) begin
		code_mem[init_i] = 8'hFF;
	end
	for (init_i = 0; init_i < 64; init_i = init_i + 1) begin
		dee_mem[init_i] = 8'hFF;
	end
	code_mem[10'h3FE] = `NVM_CFG1_RESET;
	code_mem[10'h3FF] = `NVM_CFG2_RESET;
end
reg [7:0] cfg1_r;
reg [7:0] cfg1_nxt;
reg [7:0] cfg2_r;
reg [1:0] state_r;
reg [2:0] ld_cnt_r;
reg wr_start;
reg [2:0] rg;
wire dee_busy;
wire prog_req;
wire [9:0] code_idx;
wire both_locked;

nvm_pin_sync u_prog_sync (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.pin_in(prog_mode_pin),
	.level_out(prog_req)
);

nvm_write_timer #(
	.WRITE_CYCLES(WRITE_CYCLES)
) u_wr_timer (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.start(wr_start),
	.busy(dee_busy)
);

assign code_idx = bus_addr[9:0];
assign both_locked = cfg1_r[`NVM_BIT_RD_LOCK] & cfg1_r[`NVM_BIT_WR_LOCK];

always @* begin
	rg = region(bus_addr);
	wr_start = 1'b0;
	// stores into the eeprom window start the timed cycle
	if (state_r == ST_RUN && bus_wr && rg == RG_DEE && !dee_busy) begin // [RULE21]
		if (!(cfg1_r[`NVM_BIT_UB_LOCK] &&
			bus_addr >= `NVM_DEE_UPPER_LO)) // [RULE14]
			wr_start = 1'b1;
	end
end

// config one write: locks only drop while the write lock is clear
always @* begin
	cfg1_nxt = bus_wdata;
	if (cfg1_r[`NVM_BIT_WR_LOCK]) begin
		cfg1_nxt = cfg1_r; // [RULE19]
	end
end

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		state_r <= ST_LOAD1;
		ld_cnt_r <= 3'd0;
		cfg1_r <= `NVM_CFG1_RESET;
		cfg2_r <= `NVM_CFG2_RESET;
		config_loaded <= 1'b0;
		prog_mode_active <= 1'b0;
	end else begin
		case (state_r)
		ST_LOAD1: begin
			ld_cnt_r <= ld_cnt_r + 3'd1;
			if (ld_cnt_r == `NVM_LOAD_CYCLES - 1) begin
				cfg1_r <= code_mem[10'h3FE]; // [RULE9]
				ld_cnt_r <= 3'd0;
				state_r <= ST_LOAD2;
			end
		end
		ST_LOAD2: begin
			ld_cnt_r <= ld_cnt_r + 3'd1;
			if (ld_cnt_r == `NVM_LOAD_CYCLES - 1) begin
				cfg2_r <= code_mem[10'h3FF]; // [RULE9] [RULE10]
				state_r <= ST_RUN;
				config_loaded <= 1'b1;
			end
		end
		ST_RUN: begin
			prog_mode_active <= prog_req && !both_locked; // [RULE18]
			if (prog_mode_active && bus_wr && rg == RG_CFG) begin // [RULE11]
				if (bus_addr == `NVM_CFG1_ADDR)
					cfg1_r <= cfg1_nxt; // [RULE12]
				else if (!cfg1_r[`NVM_BIT_WR_LOCK])
					cfg2_r <= bus_wdata; // [RULE10]
			end
		end
		default: begin
			state_r <= ST_LOAD1;
		end
		endcase
	end
end

// storage arrays carry no reset; contents are nonvolatile or undefined
always @(posedge ref_clk) begin
	if (state_r == ST_RUN && bus_wr) begin
		if (rg == RG_RAM)
			ram_mem[bus_addr[5:0]] <= bus_wdata; // [RULE2]
		if (wr_start)
			dee_mem[bus_addr[5:0]] <= bus_wdata; // [RULE21]
		// code writes need program mode and a clear write lock
		if ((rg == RG_CODE || rg == RG_VEC || rg == RG_CFG) &&
			prog_mode_active && !cfg1_r[`NVM_BIT_WR_LOCK]) // [RULE4] [RULE5]
			code_mem[code_idx] <= bus_wdata;
	end
end

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		bus_rdata <= 8'h00;
		bus_ack <= 1'b0;
		periph_sel <= 1'b0;
		core_reg_sel <= 1'b0;
	end else begin
		bus_ack <= (bus_rd || bus_wr) && state_r == ST_RUN;
		periph_sel <= (bus_rd || bus_wr) && rg == RG_PERI; // [RULE1]
		core_reg_sel <= (bus_rd || bus_wr) && rg == RG_STAT; // [RULE1]
		bus_rdata <= 8'h00;
		if (bus_rd && state_r == ST_RUN) begin
			case (rg)
			RG_RAM: bus_rdata <= ram_mem[bus_addr[5:0]];
			RG_DEE: begin
				if (!(prog_mode_active && cfg1_r[`NVM_BIT_RD_LOCK])) // [RULE13]
					bus_rdata <= dee_mem[bus_addr[5:0]];
			end
			RG_CODE, RG_VEC: begin
				if (!(prog_mode_active && cfg1_r[`NVM_BIT_RD_LOCK])) // [RULE13]
					bus_rdata <= code_mem[code_idx];
			end
			RG_STAT: bus_rdata <= {7'h00, nvm_ready}; // [RULE6]
			RG_CFG: begin
				if (prog_mode_active && !cfg1_r[`NVM_BIT_RD_LOCK]) // [RULE11]
					bus_rdata <= (bus_addr == `NVM_CFG1_ADDR) ? cfg1_r : cfg2_r;
			end
			default: bus_rdata <= 8'h00;
			endcase
		end
	end
end

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		nvm_ready <= 1'b0;
		low_battery_detector_on <= 1'b0;
		brownout_reset_req <= 1'b0;
		watchdog_enable_bit <= 1'b0;
		clock_mode_sel <= 2'b00;
		osc_trim <= `NVM_CFG2_RESET;
	end else begin
		// ready drops with the store and returns when the timer expires
		nvm_ready <= state_r == ST_RUN && !dee_busy && !wr_start; // [RULE7]
		low_battery_detector_on <= cfg1_r[`NVM_BIT_LBD_EN]; // [RULE15]
		brownout_reset_req <= cfg1_r[`NVM_BIT_BOR_EN] && supply_low; // [RULE16]
		watchdog_enable_bit <= cfg1_r[`NVM_BIT_WD_EN]; // [RULE17]
		clock_mode_sel <= {cfg1_r[`NVM_BIT_CLOCK_MODE_BIT_ONE],
			cfg1_r[`NVM_BIT_CLOCK_MODE_BIT_ZERO]}; // [RULE20]
		osc_trim <= cfg2_r; // [RULE10]
	end
end
endmodule // nvm_ctrl

/* testbench/nvm_core_model.sv */
// core-side load/store master model
`timescale 1ns/1ps
module nvm_core_model (
	input wire ref_clk,
	output logic [11:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd,
	input wire [7:0] bus_rdata,
	input wire bus_ack
);
initial begin
	bus_addr = 12'h000;
	bus_wdata = 8'h00;
	bus_wr = 1'b0;
	bus_rd = 1'b0;
end
// strobe lasts one cycle, a longer one would be a second access
task xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
	output logic [7:0] q, output logic ok);
	ok = 1'b0;
	@(posedge ref_clk);
	bus_addr <= a;
	bus_wdata <= d;
	bus_wr <= w;
	bus_rd <= !w;
	@(posedge ref_clk);
	bus_wr <= 1'b0;
	bus_rd <= 1'b0;
	repeat (3) begin
		@(posedge ref_clk);
		if (!ok && bus_ack) begin
			q = bus_rdata;
			ok = 1'b1;
			// released lines must not keep the old value
			bus_addr <= ~a;
			bus_wdata <= ~d;
		end
	end
endtask
endmodule // nvm_core_model

/* testbench/nvm_ctrl_monitor.sv */
// port assertions for the nvm controller
`timescale 1ns/1ps
module nvm_ctrl_monitor #(
	parameter WRITE_CYCLES = 30000
) (
	input wire ref_clk,
	input wire arst_n,
	input wire [11:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_rdata,
	input wire bus_ack,
	input wire nvm_ready,
	input wire prog_mode_active,
	input wire config_loaded,
	input wire periph_sel,
	input wire core_reg_sel
);
wire acc_v = (bus_rd || bus_wr) && config_loaded;
int busy_cnt;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n)
		busy_cnt <= 0;
	else
		busy_cnt <= nvm_ready ? 0 : busy_cnt + 1;
end
default clocking @(posedge ref_clk); endclocking
default disable iff (!arst_n);
sequence s_dee_store;
	bus_wr && config_loaded && nvm_ready && !prog_mode_active &&
		bus_addr >= 12'h040 && bus_addr <= 12'h05F;
endsequence
sequence s_busy8;
	!nvm_ready [*8];
endsequence
property p_ack;
	acc_v |=> bus_ack;
endproperty
property p_ack_cause;
	bus_ack |-> $past(acc_v);
endproperty
property p_busy_start;
	s_dee_store |=> s_busy8;
endproperty
// load phase keeps ready low too, hence the margin
property p_busy_end;
	busy_cnt <= WRITE_CYCLES + 12;
endproperty
property p_status;
	bus_rd && config_loaded && bus_addr == 12'h0CF |=>
		bus_rdata == {7'h00, $past(nvm_ready)} && core_reg_sel;
endproperty
property p_periph;
	acc_v && bus_addr >= 12'h080 && bus_addr <= 12'h0CE |=> periph_sel;
endproperty
property p_cfg_ref;
	bus_rd && config_loaded && !prog_mode_active && bus_addr >= 12'hFFE
		|=> bus_rdata == 8'h00;
endproperty
property p_loaded;
	config_loaded |=> config_loaded;
endproperty
a_ack: assert property (p_ack)
	else $error("missing ack");
a_ack_cause: assert property (p_ack_cause)
	else $error("ack without access");
a_busy_start: assert property (p_busy_start)
	else $error("store did not go busy");
a_busy_end: assert property (p_busy_end)
	else $error("busy too long");
a_status: assert property (p_status)
	else $error("bad status read");
a_periph: assert property (p_periph)
	else $error("peripheral not selected");
a_cfg_ref: assert property (p_cfg_ref)
	else $error("config read outside prog mode");
a_loaded: assert property (p_loaded)
	else $error("config load dropped");
endmodule // nvm_ctrl_monitor
bind nvm_ctrl nvm_ctrl_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_mon (
	.ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.bus_ack(bus_ack), .nvm_ready(nvm_ready),
	.prog_mode_active(prog_mode_active), .config_loaded(config_loaded),
	.periph_sel(periph_sel), .core_reg_sel(core_reg_sel));

/* testbench/testbench.sv */
// self-checking bench for the nvm controller
`timescale 1ns/1ps
module testbench;
logic ref_clk = 1'b0;
logic arst_n = 1'b0;
logic prog_mode_pin = 1'b0;
wire [11:0] bus_addr;
wire [7:0] bus_wdata, bus_rdata, osc_trim;
wire bus_wr, bus_rd, bus_ack, nvm_ready, prog_mode_active, config_loaded;
int err_total = 0;
int compares = 0;
int n;
logic [7:0] q;
always #50 ref_clk = ~ref_clk;
nvm_core_model i_nvm_core_model (.ref_clk(ref_clk), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .bus_ack(bus_ack));
nvm_ctrl #(.WRITE_CYCLES(20)) i_nvm_ctrl (.ref_clk(ref_clk),
	.arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.bus_ack(bus_ack), .prog_mode_pin(prog_mode_pin), .supply_low(1'b0),
	.nvm_ready(nvm_ready), .prog_mode_active(prog_mode_active),
	.low_battery_detector_on(), .brownout_reset_req(),
	.watchdog_enable_bit(), .clock_mode_sel(), .osc_trim(osc_trim),
	.config_loaded(config_loaded), .periph_sel(), .core_reg_sel());
task stop_test;
	if (err_total == 0 && compares > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task chk(input logic [7:0] got, input logic [7:0] exp);
	compares++;
	if (got !== exp) begin
		err_total++;
		$display("wrong value at %0t: got %h exp %h", $time, got, exp);
	end
endtask
task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
	logic ok;
	i_nvm_core_model.xfer(w, a, d, q, ok);
	if (!ok) begin
		err_total++;
		stop_test;
	end
endtask
task waitsig(input int sel, input int lim);
	n = 0;
	while ((sel == 0 ? config_loaded : sel == 1 ? nvm_ready
		: prog_mode_active) !== 1'b1) begin
		@(posedge ref_clk);
		#1;
		n++;
		if (n > lim) begin
			err_total++;
			stop_test;
		end
	end
endtask
task rd_chk(input logic [11:0] a, input logic [7:0] exp);
	acc(1'b0, a, 8'h00);
	chk(q, exp);
endtask
initial begin
	repeat (8) @(posedge ref_clk);
	chk(osc_trim, 8'h80);
	arst_n <= 1'b1;
	waitsig(0, 20);
	acc(1'b1, 12'h03F, 8'hA5);
	rd_chk(12'h03F, 8'hA5);
	rd_chk(12'h0CF, 8'h01);
	acc(1'b1, 12'h045, 8'h5A);
	chk({7'h00, nvm_ready}, 8'h00);
	rd_chk(12'h0CF, 8'h00);
	waitsig(1, 40);
	chk({7'h00, n >= 10 && n <= 25}, 8'h01);
	rd_chk(12'h045, 8'h5A);
	rd_chk(12'h0AE, 8'h00);
	rd_chk(12'hFFE, 8'h00);
	acc(1'b1, 12'hC10, 8'h00);
	rd_chk(12'hC10, 8'hFF);
	prog_mode_pin <= 1'b1;
	waitsig(2, 20);
	acc(1'b1, 12'hC10, 8'h3C);
	rd_chk(12'hC10, 8'h3C);
	acc(1'b1, 12'hFFF, 8'h7E);
	rd_chk(12'hFFF, 8'h7E);
	acc(1'b1, 12'hFFE, 8'h05);
	rd_chk(12'h045, 8'h00);
	acc(1'b1, 12'h060, 8'h00);
	waitsig(1, 40);
	acc(1'b1, 12'hFFE, 8'h00);
	rd_chk(12'h060, 8'hFF);
	stop_test;
end
endmodule // testbench
